// File: logic/bdm_pkg.sv
// Constants, offsets and carrier types of the banked data memory block.
// Assumes one 100 MHz clock and a core that issues one access per cycle.

package bdm_pkg;

	// ************************************************************
	// Widths
	// ************************************************************
	localparam int BANK_W = 5;
	localparam int OFF_W  = 7;
	localparam int PTR_W  = 16;
	localparam int DATA_W = 8;

	// ************************************************************
	// Core register offsets
	// ************************************************************
	localparam logic [6:0] OFF_IND0     = 7'h00;
	localparam logic [6:0] OFF_IND1     = 7'h01;
	localparam logic [6:0] OFF_PTR0_LO  = 7'h04;
	localparam logic [6:0] OFF_PTR0_HI  = 7'h05;
	localparam logic [6:0] OFF_PTR1_LO  = 7'h06;
	localparam logic [6:0] OFF_PTR1_HI  = 7'h07;
	localparam logic [6:0] OFF_BANK     = 7'h08;
	localparam logic [6:0] OFF_PWR      = 7'h09;
	localparam logic [6:0] OFF_INT_STAT = 7'h0a;
	localparam logic [6:0] OFF_INT_MASK = 7'h0b;

	// ************************************************************
	// Bank layout
	// ************************************************************
	localparam logic [6:0] CORE_HI      = 7'h0b;
	localparam logic [6:0] PERIPH_LO    = 7'h0c;
	localparam logic [6:0] PERIPH_HI    = 7'h1f;
	localparam logic [6:0] GPR_LO       = 7'h20;
	localparam logic [6:0] GPR_BYTES    = 7'h50;
	localparam logic [6:0] COMMON_LO    = 7'h70;
	localparam int         COMMON_BYTES = 16;

	// ************************************************************
	// Indirect address space
	// ************************************************************
	localparam logic [15:0] TRAD_LIMIT = 16'h1000;
	localparam logic [15:0] LIN_BASE   = 16'h2000;
	localparam logic [15:0] FLASH_BASE = 16'h8000;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int PWR_ENA_BIT   = 0;
	localparam int PWR_UNF_BIT   = 6;
	localparam int PWR_OVF_BIT   = 7;
	localparam int INT_OVF_BIT   = 0;
	localparam int INT_UNF_BIT   = 1;
	localparam int INT_SELF_BIT  = 2;
	localparam logic [7:0] INT_BITS_MASK = 8'h07;

	// ************************************************************
	// Reset values and counts
	// ************************************************************
	localparam logic [4:0]  BANK_RST     = 5'h00;
	localparam logic [15:0] PTR_RST      = 16'h0000;
	localparam logic [7:0]  INT_RST      = 8'h00;
	localparam logic [4:0]  STACK_LEVELS = 5'h10;

	// ************************************************************
	// Carrier types
	// ************************************************************
	typedef enum logic [1:0] {
		KIND_NONE,
		KIND_CORE,
		KIND_RAM
	} bdm_kind_type;

	typedef struct packed {
		bdm_kind_type kind;
		logic         self_ref;
		logic         flash;
		logic [6:0]   off;
		logic [15:0]  idx;
	} bdm_target_type;

endpackage

// File: logic/bdm_ram.sv
// Byte storage for banked general purpose RAM and common RAM.
// Assumes the caller gives a valid index; read is combinational.
`timescale 1ns/1ps

module bdm_ram
	import bdm_pkg::*;
#(
	parameter int DEPTH = 176,
	parameter int AW    = 8
) (
	input  wire logic          ref_clk_in, // System clock
	input  wire logic          we_in,      // Write enable
	input  wire logic [AW-1:0] addr_in,    // Byte index
	input  wire logic [7:0]    wdata_in,   // Write data
	output logic      [7:0]    rdata_out   // Read data, same cycle
);

	logic [7:0] mem [DEPTH];

	always_ff @(posedge ref_clk_in) begin
		if (we_in) begin
			mem[addr_in] <= wdata_in;
		end
	end

	assign rdata_out = mem[addr_in];

endmodule

// File: logic/bdm_top.sv
// Data memory map, bank and pointer address generation, stack guard.
// Assumes the core drives one access strobe at a time on ref_clk_in.
`timescale 1ns/1ps

module bdm_top
	import bdm_pkg::*;
#(
	parameter int NUM_BANKS = 2
) (
	input  wire logic       ref_clk_in,   // System clock, 100 MHz
	input  wire logic       rstn_in,      // Async reset, active low
	input  wire logic [6:0] addr_in,      // Bank offset from instruction
	input  wire logic [7:0] wdata_in,     // Write data
	input  wire logic       wr_in,        // Write strobe
	input  wire logic       rd_in,        // Read strobe
	input  wire logic       push_in,      // Stack push pulse
	input  wire logic       pop_in,       // Stack pop pulse
	input  wire logic       fault_en_in,  // Stack fault reset option pin
	output logic      [7:0] rdata_out,    // Read data, cycle after strobe
	output logic            stack_reset_out, // Stack fault reset pulse
	output logic            irq_out       // Interrupt, level
);

	// ************************************************************
	// Sizes
	// ************************************************************
	localparam int GPR_TOTAL  = NUM_BANKS * int'(GPR_BYTES);
	localparam int RAM_DEPTH  = GPR_TOTAL + COMMON_BYTES;
	localparam int RAM_AW     = $clog2(RAM_DEPTH);
	localparam logic [15:0] GPR_TOTAL16 = 16'(GPR_TOTAL);
	localparam logic [4:0]  BANKS5      = 5'(NUM_BANKS);

	// ************************************************************
	// State
	// ************************************************************
	logic [4:0]  bank;
	logic [4:0]  next_bank;
	logic [15:0] ptr0;
	logic [15:0] next_ptr0;
	logic [15:0] ptr1;
	logic [15:0] next_ptr1;
	logic        flag_ovf;
	logic        next_flag_ovf;
	logic        flag_unf;
	logic        next_flag_unf;
	logic [7:0]  int_stat;
	logic [7:0]  next_int_stat;
	logic [7:0]  int_mask;
	logic [7:0]  next_int_mask;
	logic [4:0]  depth;
	logic [4:0]  next_depth;
	logic [7:0]  next_rdata;
	logic        next_stack_reset;
	logic        next_irq;

	logic        sync1;
	logic        sync2;
	logic        sync3;
	logic        fault_en;
	logic        next_fault_en;

	bdm_target_type tgt;
	logic           ram_we;
	logic [7:0]     ram_q;
	logic           ovf_evt;
	logic           unf_evt;
	logic           self_evt;

	// ************************************************************
	// Address decode functions
	// ************************************************************
	function automatic bdm_target_type map_banked(input logic [4:0] b, input logic [6:0] off);
		bdm_target_type t;
		t = '0;
		t.kind = KIND_NONE;
		t.off = off;
		if (off >= COMMON_LO) begin
			t.kind = KIND_RAM;
			t.idx = GPR_TOTAL16 + 16'(off - COMMON_LO);
		end else if (off >= GPR_LO && off < GPR_LO + GPR_BYTES) begin
			if (b < BANKS5) begin
				t.kind = KIND_RAM;
				t.idx = 16'(b) * 16'(GPR_BYTES) + 16'(off - GPR_LO);
			end
		end else if (off <= CORE_HI) begin
			t.kind = KIND_CORE;
		end else if (off >= PERIPH_LO && off <= PERIPH_HI) begin
			t.kind = KIND_NONE;
		end
		return t;
	endfunction

	function automatic bdm_target_type map_pointer(input logic [15:0] p);
		bdm_target_type t;
		logic [15:0]    lin;
		t = '0;
		t.kind = KIND_NONE;
		lin = p - LIN_BASE;
		if (p < TRAD_LIMIT) begin
			t = map_banked(p[11:7], p[6:0]);
			if (t.kind == KIND_CORE && (p[6:0] == OFF_IND0 || p[6:0] == OFF_IND1)) begin
				t.kind = KIND_NONE;
				t.self_ref = 1'b1;
			end
		end else if (p >= LIN_BASE && p < FLASH_BASE) begin
			if (lin < GPR_TOTAL16) begin
				t.kind = KIND_RAM;
				t.idx = lin;
			end
		end else begin
			t.flash = 1'b1;
		end
		return t;
	endfunction

	function automatic logic [7:0] core_read(input logic [6:0] off, input logic [15:0] p0,
			input logic [15:0] p1, input logic [4:0] b, input logic [7:0] pwr,
			input logic [7:0] st, input logic [7:0] mk);
		logic [7:0] v;
		v = 8'h00;
		case (off)
			OFF_PTR0_LO:  v = p0[7:0];
			OFF_PTR0_HI:  v = p0[15:8];
			OFF_PTR1_LO:  v = p1[7:0];
			OFF_PTR1_HI:  v = p1[15:8];
			OFF_BANK:     v = {3'h0, b};
			OFF_PWR:      v = pwr;
			OFF_INT_STAT: v = st;
			OFF_INT_MASK: v = mk;
			default:      v = 8'h00;
		endcase
		return v;
	endfunction

	// ************************************************************
	// Option pin synchroniser
	// ************************************************************
	always_comb begin
		next_fault_en = fault_en;
		if (sync2 == sync3) begin
			next_fault_en = sync3;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sync1    <= 1'b0;
			sync2    <= 1'b0;
			sync3    <= 1'b0;
			fault_en <= 1'b0;
		end else begin
			sync1    <= fault_en_in;
			sync2    <= sync1;
			sync3    <= sync2;
			fault_en <= next_fault_en;
		end
	end

	// ************************************************************
	// Access target
	// ************************************************************
	always_comb begin
		if (addr_in == OFF_IND0) begin
			tgt = map_pointer(ptr0);
		end else if (addr_in == OFF_IND1) begin
			tgt = map_pointer(ptr1);
		end else begin
			tgt = map_banked(bank, addr_in);
		end
	end

	assign ram_we = wr_in && (tgt.kind == KIND_RAM);

	bdm_ram #(
		.DEPTH (RAM_DEPTH),
		.AW    (RAM_AW)
	) u_ram (
		.ref_clk_in (ref_clk_in),
		.we_in      (ram_we),
		.addr_in    (tgt.idx[RAM_AW-1:0]),
		.wdata_in   (wdata_in),
		.rdata_out  (ram_q)
	);

	// ************************************************************
	// Stack guard
	// ************************************************************
	always_comb begin
		next_depth       = depth;
		ovf_evt          = 1'b0;
		unf_evt          = 1'b0;
		if (push_in && !pop_in) begin
			if (depth == STACK_LEVELS) begin
				ovf_evt = 1'b1;
			end else begin
				next_depth = depth + 5'h01;
			end
		end else if (pop_in && !push_in) begin
			if (depth == 5'h00) begin
				unf_evt = 1'b1;
			end else begin
				next_depth = depth - 5'h01;
			end
		end
		next_stack_reset = (ovf_evt || unf_evt) && fault_en;
		if (next_stack_reset) begin
			next_depth = 5'h00;
		end
	end

	// ************************************************************
	// Registers, flags and read data
	// ************************************************************
	assign self_evt = (rd_in || wr_in) && tgt.self_ref;

	always_comb begin
		next_bank     = bank;
		next_ptr0     = ptr0;
		next_ptr1     = ptr1;
		next_flag_ovf = flag_ovf;
		next_flag_unf = flag_unf;
		next_int_stat = int_stat;
		next_int_mask = int_mask;
		next_rdata    = 8'h00;

		if (wr_in && tgt.kind == KIND_CORE) begin
			case (tgt.off)
				OFF_PTR0_LO:  next_ptr0[7:0]  = wdata_in;
				OFF_PTR0_HI:  next_ptr0[15:8] = wdata_in;
				OFF_PTR1_LO:  next_ptr1[7:0]  = wdata_in;
				OFF_PTR1_HI:  next_ptr1[15:8] = wdata_in;
				OFF_BANK:     next_bank       = wdata_in[4:0];
				OFF_PWR: begin
					next_flag_ovf = flag_ovf & wdata_in[PWR_OVF_BIT];
					next_flag_unf = flag_unf & wdata_in[PWR_UNF_BIT];
				end
				OFF_INT_STAT: next_int_stat = int_stat & ~wdata_in;
				OFF_INT_MASK: next_int_mask = wdata_in & INT_BITS_MASK;
				default:      next_bank     = bank;
			endcase
		end

		if (next_stack_reset && ovf_evt) begin
			next_flag_ovf = 1'b1;
		end
		if (next_stack_reset && unf_evt) begin
			next_flag_unf = 1'b1;
		end
		next_int_stat[INT_OVF_BIT]  = next_int_stat[INT_OVF_BIT] | ovf_evt;
		next_int_stat[INT_UNF_BIT]  = next_int_stat[INT_UNF_BIT] | unf_evt;
		next_int_stat[INT_SELF_BIT] = next_int_stat[INT_SELF_BIT] | self_evt;

		if (rd_in) begin
			case (tgt.kind)
				KIND_RAM:  next_rdata = ram_q;
				KIND_CORE: next_rdata = core_read(tgt.off, ptr0, ptr1, bank,
					{flag_ovf, flag_unf, 5'h00, fault_en}, int_stat, int_mask);
				default:   next_rdata = 8'h00;
			endcase
		end

		// Mask and status both taken at their next values, so irq_out tracks them
		next_irq = |(next_int_stat & next_int_mask);
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			bank            <= BANK_RST;
			ptr0            <= PTR_RST;
			ptr1            <= PTR_RST;
			flag_ovf        <= 1'b0;
			flag_unf        <= 1'b0;
			int_stat        <= INT_RST;
			int_mask        <= INT_RST;
			depth           <= 5'h00;
			rdata_out       <= 8'h00;
			stack_reset_out <= 1'b0;
			irq_out         <= 1'b0;
		end else begin
			bank            <= next_bank;
			ptr0            <= next_ptr0;
			ptr1            <= next_ptr1;
			flag_ovf        <= next_flag_ovf;
			flag_unf        <= next_flag_unf;
			int_stat        <= next_int_stat;
			int_mask        <= next_int_mask;
			depth           <= next_depth;
			rdata_out       <= next_rdata;
			stack_reset_out <= next_stack_reset;
			irq_out         <= next_irq;
		end
	end

endmodule

// File: tb/bdm_core_model.sv
// Core stand-in issuing stack pushes and pops.
// Assumes callers enter its task between clock edges.
`timescale 1ns/1ps

module bdm_core_model (
	input  wire logic ref_clk_in, // Clock
	output logic      push_out,   // Push pulse
	output logic      pop_out     // Pop pulse
);
	initial begin
		push_out = 1'b0;
		pop_out  = 1'b0;
	end

	// One-cycle pulses, returns at the edge of the last
	task automatic stack_op(input logic is_push, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk_in);
			push_out <= is_push;
			pop_out  <= !is_push;
			@(posedge ref_clk_in);
			push_out <= 1'b0;
			pop_out  <= 1'b0;
		end
	endtask
endmodule

// File: tb/bdm_top_assertions.sv
// Port checker for the banked data memory block.
// Assumes the option pin stays steady around stack faults.
`timescale 1ns/1ps

module bdm_top_assertions
	import bdm_pkg::*;
(
	input wire logic       ref_clk_in,      // Clock
	input wire logic       rstn_in,         // Reset, active low
	input wire logic [6:0] addr_in,         // Offset
	input wire logic [7:0] wdata_in,        // Write data
	input wire logic       wr_in,           // Write strobe
	input wire logic       rd_in,           // Read strobe
	input wire logic       push_in,         // Push
	input wire logic       pop_in,          // Pop
	input wire logic       fault_en_in,     // Option pin
	input wire logic [7:0] rdata_out,       // Read data
	input wire logic       stack_reset_out, // Stack reset
	input wire logic       irq_out          // Interrupt
);
	// ****
	// Stack depth shadow
	// ****
	logic [4:0] depth;
	logic [4:0] next_depth;
	logic [5:0] opt_hist;
	logic       ovf_ev;
	logic       unf_ev;
	logic       on6;
	logic       off6;

	assign ovf_ev = push_in && !pop_in && depth == STACK_LEVELS;
	assign unf_ev = pop_in && !push_in && depth == 5'h00;
	assign on6    = &opt_hist;
	assign off6   = ~|opt_hist;

	always_comb begin
		next_depth = depth;
		if ((ovf_ev || unf_ev) && on6) begin
			next_depth = 5'h00;
		end else if (push_in && !pop_in && !ovf_ev) begin
			next_depth = depth + 5'h01;
		end else if (pop_in && !push_in && !unf_ev) begin
			next_depth = depth - 5'h01;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			depth    <= 5'h00;
			opt_hist <= 6'h00;
		end else begin
			depth    <= next_depth;
			opt_hist <= {opt_hist[4:0], fault_en_in};
		end
	end

	// ****
	// Assertions
	// ****
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rstn_in);

	a_ovf_reset: assert property (ovf_ev && on6 |=> stack_reset_out)
		else $error("no stack reset after overflow");
	a_unf_reset: assert property (unf_ev && on6 |=> stack_reset_out)
		else $error("no stack reset after underflow");
	a_fault_cause: assert property (stack_reset_out |-> $past(ovf_ev) || $past(unf_ev))
		else $error("stack reset without fault");
	a_opt_off_quiet: assert property ((ovf_ev || unf_ev) && off6 |=> !stack_reset_out)
		else $error("stack reset with option off");
	a_reset_pulse: assert property (stack_reset_out |=> !stack_reset_out)
		else $error("stack reset longer than one cycle");
	a_rdata_idle: assert property (!rd_in |=> rdata_out == 8'h00)
		else $error("read data without read");
	a_irq_rise: assert property ($rose(irq_out) |->
		$past(push_in) || $past(pop_in) || $past(rd_in) || $past(wr_in))
		else $error("interrupt rose without cause");
	a_irq_fall: assert property ($fell(irq_out) |-> $past(wr_in))
		else $error("interrupt fell without write");
endmodule

// File: tb/bdm_top_tb_top.sv
// Bench for the banked data memory block: map, pointers, stack guard.
// Assumes two banks and the core model for stack traffic.
`timescale 1ns/1ps

module bdm_top_tb_top
	import bdm_pkg::*;
;
	logic       clk;
	logic       rstn;
	logic [6:0] addr;
	logic [7:0] wd;
	logic       wr;
	logic       rd;
	logic       fen;
	logic       push;
	logic       pop;
	logic [7:0] rdata;
	logic       srst;
	logic       irq;
	int         fails;
	int         cmp_count;

	bdm_top #(.NUM_BANKS(2)) DUT (.ref_clk_in(clk), .rstn_in(rstn), .addr_in(addr),
		.wdata_in(wd), .wr_in(wr), .rd_in(rd), .push_in(push), .pop_in(pop),
		.fault_en_in(fen), .rdata_out(rdata), .stack_reset_out(srst), .irq_out(irq));
	bdm_core_model core (.ref_clk_in(clk), .push_out(push), .pop_out(pop));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		wr   <= 1'b1;
		addr <= a;
		wd   <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
		@(posedge clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask

	task automatic ptr(input logic [6:0] lo, input logic [15:0] p);
		wr_reg(lo, p[7:0]);
		wr_reg(lo + 7'h01, p[15:8]);
	endtask

	task automatic t_reset;
		rd_chk(OFF_BANK, 8'h00);
		rd_chk(OFF_PTR0_LO, 8'h00);
		rd_chk(OFF_PWR, 8'h00);
		chk({7'h00, irq}, 8'h00);
		$display("reset test done");
	endtask

	task automatic t_map;
		wr_reg(GPR_LO, 8'ha1);
		wr_reg(7'h6f, 8'ha2);
		wr_reg(PERIPH_LO, 8'h55);
		wr_reg(PERIPH_HI, 8'h55);
		wr_reg(OFF_BANK, 8'h01);
		wr_reg(GPR_LO, 8'hb1);
		wr_reg(7'h7f, 8'hc1);
		rd_chk(GPR_LO, 8'hb1);
		wr_reg(OFF_BANK, 8'h00);
		rd_chk(GPR_LO, 8'ha1);
		rd_chk(7'h6f, 8'ha2);
		rd_chk(7'h7f, 8'hc1);
		rd_chk(PERIPH_LO, 8'h00);
		rd_chk(PERIPH_HI, 8'h00);
		rd_chk(7'h03, 8'h00);
		$display("map test done");
	endtask

	task automatic t_ind;
		ptr(OFF_PTR0_LO, 16'h0020);
		rd_chk(OFF_IND0, 8'ha1);
		ptr(OFF_PTR1_LO, 16'h00a0);
		rd_chk(OFF_IND1, 8'hb1);
		ptr(OFF_PTR1_LO, 16'h00ff);
		rd_chk(OFF_IND1, 8'hc1);
		ptr(OFF_PTR1_LO, 16'h2050);
		rd_chk(OFF_IND1, 8'hb1);
		wr_reg(OFF_IND1, 8'h5a);
		ptr(OFF_PTR0_LO, 16'h204f);
		rd_chk(OFF_PTR0_HI, 8'h20);
		rd_chk(OFF_PTR0_LO, 8'h4f);
		rd_chk(OFF_IND0, 8'ha2);
		ptr(OFF_PTR0_LO, 16'h8000);
		rd_chk(OFF_IND0, 8'h00);
		wr_reg(OFF_BANK, 8'h01);
		rd_chk(GPR_LO, 8'h5a);
		wr_reg(OFF_BANK, 8'h00);
		$display("pointer test done");
	endtask

	task automatic t_self;
		ptr(OFF_PTR0_LO, 16'h0001);
		wr_reg(OFF_IND0, 8'h77);
		rd_chk(OFF_IND0, 8'h00);
		rd_chk(OFF_INT_STAT, 8'h04);
		ptr(OFF_PTR1_LO, 16'h0080);
		rd_chk(OFF_IND1, 8'h00);
		chk({7'h00, irq}, 8'h00);
		wr_reg(OFF_INT_MASK, 8'h04);
		#1;
		chk({7'h00, irq}, 8'h01);
		wr_reg(OFF_INT_STAT, 8'h04);
		#1;
		chk({7'h00, irq}, 8'h00);
		$display("self reference test done");
	endtask

	task automatic t_stack;
		core.stack_op(1'b0, 1);
		#1;
		chk({7'h00, srst}, 8'h00);
		rd_chk(OFF_PWR, 8'h00);
		@(posedge clk);
		fen <= 1'b1;
		repeat (8) @(posedge clk);
		core.stack_op(1'b1, 16);
		#1;
		chk({7'h00, srst}, 8'h00);
		core.stack_op(1'b1, 1);
		#1;
		chk({7'h00, srst}, 8'h01);
		rd_chk(OFF_PWR, 8'h81);
		core.stack_op(1'b0, 1);
		#1;
		chk({7'h00, srst}, 8'h01);
		rd_chk(OFF_PWR, 8'hc1);
		rd_chk(OFF_INT_STAT, 8'h03);
		chk({7'h00, irq}, 8'h00);
		wr_reg(OFF_PWR, 8'h00);
		rd_chk(OFF_PWR, 8'h01);
		wr_reg(OFF_INT_MASK, 8'h01);
		#1;
		chk({7'h00, irq}, 8'h01);
		$display("stack test done");
	endtask

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		rstn = 1'b0;
		addr = 7'h00;
		wd = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		fen = 1'b0;
		fails = 0;
		cmp_count = 0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_map();
		t_ind();
		t_self();
		t_stack();
		wrap_up();
	end

	initial begin
		#20000;
		fails++;
		$display("mismatch at %0t: watchdog", $time);
		wrap_up();
	end
endmodule

bind bdm_top bdm_top_assertions u_chk (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
	.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
	.push_in(push_in), .pop_in(pop_in), .fault_en_in(fault_en_in),
	.rdata_out(rdata_out), .stack_reset_out(stack_reset_out), .irq_out(irq_out));
